/* include/sbot_pkg.sv */
package sbot_pkg;

  // Register byte addresses on the plain register port.
  localparam logic [15:0] SBOT_ADDR_MODE   = 16'hFF80;
  localparam logic [15:0] SBOT_ADDR_CTRL   = 16'hFF81;
  localparam logic [15:0] SBOT_ADDR_IEN    = 16'hFF82;
  localparam logic [15:0] SBOT_ADDR_STAT   = 16'hFF83;
  localparam logic [15:0] SBOT_ADDR_CNT_HI = 16'hFF86;
  localparam logic [15:0] SBOT_ADDR_CNT_LO = 16'hFF87;

  // Field positions.
  localparam int SBOT_RUN_BIT  = 7;
  localparam int SBOT_CKS_MSB  = 6;
  localparam int SBOT_CKS_LSB  = 4;
  localparam int SBOT_OVERFLOW_IRQ_ENABLE_BIT = 7;
  localparam int SBOT_OVF_BIT  = 7;

  // Values after reset.
  localparam logic [7:0]  SBOT_MODE_RST = 8'hC8;
  localparam logic [7:0]  SBOT_CTRL_RST = 8'h30;
  localparam logic [7:0]  SBOT_IEN_RST  = 8'h00;
  localparam logic [7:0]  SBOT_STAT_RST = 8'h00;
  localparam logic [15:0] SBOT_CNT_RST  = 16'h0000;

  // Clock select codes: 0..3 divide by 1, 2, 4, 8; 4..7 give no tick.
  localparam logic [2:0] SBOT_CKS_DIV1 = 3'h0;
  localparam logic [2:0] SBOT_CKS_DIV8 = 3'h3;
  localparam logic [2:0] SBOT_CKS_MAX  = 3'h3;

  // System clock.
  localparam int SBOT_CLK_PERIOD_NS = 20;

  // Register decode result.
  typedef enum logic [2:0] {
    SBOT_REG_NONE   = 3'h0,
    SBOT_REG_MODE   = 3'h1,
    SBOT_REG_CTRL   = 3'h3,
    SBOT_REG_IEN    = 3'h2,
    SBOT_REG_STAT   = 3'h6,
    SBOT_REG_CNT_HI = 3'h7,
    SBOT_REG_CNT_LO = 3'h5
  } sbot_reg_t;

endpackage

/* src/sbot_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none

module sbot_prescaler #(
  parameter int PRE_W = 3
) (
  input  wire logic       clk,     // System clock.
  input  wire logic       resetn,  // Asynchronous reset, active low.
  input  wire logic       ce,      // Clock enable, freezes state when low.
  input  wire logic [2:0] sel,     // Clock select code.
  output logic            tick     // One-cycle count tick.
);

  generate
    if (PRE_W < 3) begin : g_chk
      $error("sbot_prescaler: PRE_W must be at least 3");
    end
  endgenerate

  logic [PRE_W-1:0] div_cnt;
  logic [PRE_W-1:0] mask;
  logic             next_tick;

  always_comb begin
    mask      = {PRE_W{1'b0}};
    next_tick = 1'b0;
    if (sel <= sbot_pkg::SBOT_CKS_MAX) begin
      mask      = PRE_W'((1 << sel) - 1);
      next_tick = ((div_cnt & mask) == mask);
    end
  end

  // The divider runs free so that a change of select never restarts the phase.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_cnt <= {PRE_W{1'b0}};
    end else if (ce) begin
      div_cnt <= div_cnt + PRE_W'(1);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick <= 1'b0;
    end else if (ce) begin
      tick <= next_tick;
    end
  end

endmodule

`default_nettype wire

/* src/sbot_timer.sv */
`timescale 1ns/1ps
`default_nettype none

module sbot_timer #(
  parameter int COUNT_W = 16,
  parameter int PRE_W   = 3
) (
  input  wire logic        clk,     // System clock, 50 MHz.
  input  wire logic        resetn,  // Asynchronous reset, active low.
  input  wire logic        ce,      // Clock enable, freezes all state when low.
  input  wire logic [15:0] addr,    // Register byte address.
  input  wire logic [7:0]  wdata,   // Write data.
  input  wire logic        wr,      // Write strobe.
  input  wire logic        rd,      // Read strobe.
  output logic      [7:0]  rdata,   // Read data, valid the cycle after rd.
  output logic             irq      // Overflow interrupt request, level.
);

  generate
    if (COUNT_W != 16) begin : g_chk
      $error("sbot_timer: COUNT_W must be 16 for the byte register map");
    end
    if (PRE_W < 3) begin : g_pre_chk
      $error("sbot_timer: PRE_W must be at least 3");
    end
  endgenerate

  // Exact decode, so no alias of the byte map reaches a register.
  function automatic sbot_pkg::sbot_reg_t decode(input logic [15:0] a);
    sbot_pkg::sbot_reg_t r;
    r = sbot_pkg::SBOT_REG_NONE;
    unique case (a)
      sbot_pkg::SBOT_ADDR_MODE:   r = sbot_pkg::SBOT_REG_MODE;
      sbot_pkg::SBOT_ADDR_CTRL:   r = sbot_pkg::SBOT_REG_CTRL;
      sbot_pkg::SBOT_ADDR_IEN:    r = sbot_pkg::SBOT_REG_IEN;
      sbot_pkg::SBOT_ADDR_STAT:   r = sbot_pkg::SBOT_REG_STAT;
      sbot_pkg::SBOT_ADDR_CNT_HI: r = sbot_pkg::SBOT_REG_CNT_HI;
      sbot_pkg::SBOT_ADDR_CNT_LO: r = sbot_pkg::SBOT_REG_CNT_LO;
      default:                    r = sbot_pkg::SBOT_REG_NONE;
    endcase
    return r;
  endfunction

  logic [7:0]         mode;
  logic [7:0]         ctrl;
  logic [7:0]         ien;
  logic               overflow_flag;
  logic               clear_armed;
  logic [COUNT_W-1:0] count_value;
  logic [7:0]         wr_hi_buf;
  logic [7:0]         rd_lo_buf;
  logic               tick;
  logic               step;
  logic               wrap;
  logic               cnt_load;
  logic               flag_clear;
  sbot_pkg::sbot_reg_t wsel;
  sbot_pkg::sbot_reg_t rsel;
  logic [7:0]         next_rdata;
  logic               stat_wr;
  logic               stat_rd;

  // Strobes are qualified here so that an idle address decodes to nothing.
  assign wsel = wr ? decode(addr) : sbot_pkg::SBOT_REG_NONE;
  assign rsel = rd ? decode(addr) : sbot_pkg::SBOT_REG_NONE;
  // Status accesses drive both the arming and the clear.
  assign stat_wr = (wsel == sbot_pkg::SBOT_REG_STAT);
  assign stat_rd = (rsel == sbot_pkg::SBOT_REG_STAT);

  // Codes above 011 give no tick, so a stray code halts the count.
  // prescaled clock select
  sbot_prescaler #(
    .PRE_W (PRE_W)
  ) u_pre (
    .clk    (clk),
    .resetn (resetn),
    .ce     (ce),
    .sel    (ctrl[sbot_pkg::SBOT_CKS_MSB:sbot_pkg::SBOT_CKS_LSB]),
    .tick   (tick)
  );

  assign step = tick && mode[sbot_pkg::SBOT_RUN_BIT];
  // A load from software takes precedence over a tick in the same cycle.
  assign cnt_load = (wsel == sbot_pkg::SBOT_REG_CNT_LO);
  assign wrap = step && !cnt_load && (count_value == {COUNT_W{1'b1}});

  // Every process honours ce, so a low enable freezes the whole block.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode <= sbot_pkg::SBOT_MODE_RST;
    end else if (ce && (wsel == sbot_pkg::SBOT_REG_MODE)) begin
      mode <= wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl <= sbot_pkg::SBOT_CTRL_RST;
    end else if (ce && (wsel == sbot_pkg::SBOT_REG_CTRL)) begin
      ctrl <= wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ien <= sbot_pkg::SBOT_IEN_RST;
    end else if (ce && (wsel == sbot_pkg::SBOT_REG_IEN)) begin
      ien <= wdata;
    end
  end

  // The high byte is staged so that a 16-bit load lands in one cycle.
  // Writing the low byte alone reuses the last staged high byte.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_hi_buf <= 8'h00;
    end else if (ce && (wsel == sbot_pkg::SBOT_REG_CNT_HI)) begin
      wr_hi_buf <= wdata;
    end
  end

  // A load of all ones sets no flag; only a counted wrap does.
  // sixteen-bit up count
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_value <= sbot_pkg::SBOT_CNT_RST;
    end else if (ce) begin
      if (cnt_load) begin
        count_value <= {wr_hi_buf, wdata};
      end else if (step) begin
        count_value <= count_value + COUNT_W'(1);
      end
    end
  end

  // Clearing needs a read of the flag as one, then a write of zero.
  // Any status write disarms, so a stale read cannot clear a later overflow.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clear_armed <= 1'b0;
    end else if (ce) begin
      if (stat_wr) begin
        clear_armed <= 1'b0;
      end else if (stat_rd && overflow_flag) begin
        clear_armed <= 1'b1;
      end
    end
  end

  assign flag_clear = stat_wr && clear_armed
                      && !wdata[sbot_pkg::SBOT_OVF_BIT];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      overflow_flag <= sbot_pkg::SBOT_STAT_RST[sbot_pkg::SBOT_OVF_BIT];
    end else if (ce) begin
      // A wrap in the clearing cycle wins, so no overflow is lost.
      if (wrap) begin
        overflow_flag <= 1'b1;
      end else if (flag_clear) begin
        overflow_flag <= 1'b0;
      end
    end
  end

  // The request is registered and so lags the flag by one cycle.
  // enable gates request
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= overflow_flag && ien[sbot_pkg::SBOT_OVERFLOW_IRQ_ENABLE_BIT];
    end
  end

  // Reading the high byte freezes the low byte, giving a coherent pair.
  // A low read with no high read before it returns a stale byte.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_lo_buf <= 8'h00;
    end else if (ce && (rsel == sbot_pkg::SBOT_REG_CNT_HI)) begin
      rd_lo_buf <= count_value[7:0];
    end
  end

  // Status bits other than the flag read as zero.
  always_comb begin
    next_rdata = 8'h00;
    unique case (rsel)
      sbot_pkg::SBOT_REG_MODE:   next_rdata = mode;
      sbot_pkg::SBOT_REG_CTRL:   next_rdata = ctrl;
      sbot_pkg::SBOT_REG_IEN:    next_rdata = ien;
      sbot_pkg::SBOT_REG_STAT:   next_rdata = {overflow_flag, 7'h00};
      sbot_pkg::SBOT_REG_CNT_HI: next_rdata = count_value[15:8];
      sbot_pkg::SBOT_REG_CNT_LO: next_rdata = rd_lo_buf;
      sbot_pkg::SBOT_REG_NONE:   next_rdata = 8'h00;
    endcase
  end

  // Read data stand for one cycle only and return to zero after.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 8'h00;
    end else if (ce) begin
      rdata <= next_rdata;
    end
  end

endmodule

`default_nettype wire

/* dv/sbot_timer_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module sbot_timer_checker (
  input wire logic        clk,    // Clock.
  input wire logic        resetn, // Reset, active low.
  input wire logic        ce,     // Clock enable.
  input wire logic [15:0] addr,   // Address.
  input wire logic [7:0]  wdata,  // Write data.
  input wire logic        wr,     // Write strobe.
  input wire logic        rd,     // Read strobe.
  input wire logic [7:0]  rdata,  // Read data.
  input wire logic        irq     // Request.
);
  logic [7:0] mode_sh;
  logic [7:0] ctrl_sh;
  logic [7:0] ien_sh;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Shadows of what software wrote, so readback needs no internal state.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_sh <= sbot_pkg::SBOT_MODE_RST;
      ctrl_sh <= sbot_pkg::SBOT_CTRL_RST;
      ien_sh  <= sbot_pkg::SBOT_IEN_RST;
    end else if (ce && wr) begin
      if (addr == sbot_pkg::SBOT_ADDR_MODE) mode_sh <= wdata;
      if (addr == sbot_pkg::SBOT_ADDR_CTRL) ctrl_sh <= wdata;
      if (addr == sbot_pkg::SBOT_ADDR_IEN) ien_sh <= wdata;
    end
  end
  AST_MODE_RD: assert property (rd && ce && addr == sbot_pkg::SBOT_ADDR_MODE |=>
    rdata == $past(mode_sh)) else $error("mode readback wrong");
  AST_CTRL_RD: assert property (rd && ce && addr == sbot_pkg::SBOT_ADDR_CTRL |=>
    rdata == $past(ctrl_sh)) else $error("control readback wrong");
  AST_IEN_RD: assert property (rd && ce && addr == sbot_pkg::SBOT_ADDR_IEN |=>
    rdata == $past(ien_sh)) else $error("enable readback wrong");
  AST_STAT_LOW: assert property (rd && ce && addr == sbot_pkg::SBOT_ADDR_STAT |=>
    rdata[6:0] == 7'h00) else $error("status low bits set");
  AST_IDLE_ZERO: assert property (ce && !rd |=> rdata == 8'h00)
    else $error("read data without read");
  AST_UNMAPPED: assert property (rd && ce && addr inside {16'hFF84, 16'hFF85, 16'hFF88} |=>
    rdata == 8'h00) else $error("unmapped read not zero");
  AST_IRQ_GATED: assert property ($rose(irq) |-> $past(ien_sh[7]))
    else $error("request while disabled");
  AST_IRQ_FALL: assert property ($fell(irq) |-> $past(wr && (addr == sbot_pkg::SBOT_ADDR_IEN
    || addr == sbot_pkg::SBOT_ADDR_STAT), 2)) else $error("request dropped unprompted");
  cover property ($rose(irq));
  cover property ($fell(irq));
  cover property (rd && addr == sbot_pkg::SBOT_ADDR_STAT ##1 rdata[7]);
endmodule
bind sbot_timer sbot_timer_checker sbot_timer_checker_i (.clk(clk), .resetn(resetn), .ce(ce),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
`default_nettype wire

/* dv/test_sbot_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module test_sbot_timer;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        ce = 1'b1;
  logic [7:0]  rdata;
  logic        irq;
  int          err_count = 0;
  int          n_tests = 0;
  always #10 clk = ~clk;
  sbot_timer sbot_timer_i (.clk(clk), .resetn(resetn), .ce(ce), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
  task automatic wr8(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd8(input logic [15:0] a, output logic [7:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic load(input logic [15:0] c);
    wr8(16'hFF86, c[15:8]);
    wr8(16'hFF87, c[7:0]);
  endtask
  task automatic rdc(output logic [15:0] c);
    rd8(16'hFF86, c[15:8]);
    rd8(16'hFF87, c[7:0]);
  endtask
  task automatic t_reset();
    logic [7:0] v;
    rd8(16'hFF80, v);
    `CHK("mode", 8'hC8, v)
    rd8(16'hFF83, v);
    `CHK("status", 8'h00, v)
  endtask
  task automatic t_run();
    logic [15:0] c;
    wr8(16'hFF80, 8'h00);
    load(16'h1234);
    repeat (40) @(posedge clk);
    rdc(c);
    `CHK("stopped", 16'h1234, c)
    wr8(16'hFF80, 8'h80);
    repeat (80) @(posedge clk);
    rdc(c);
    c = c - 16'h1234;
    `CHK("run_delta", 1'b1, c >= 16'h0008 && c <= 16'h000C)
  endtask
  task automatic t_sel();
    logic [15:0] c;
    int          e;
    for (int s = 0; s < 4; s++) begin
      wr8(16'hFF81, {1'b0, 3'(s), 4'h0});
      load(16'h0000);
      repeat (64) @(posedge clk);
      rdc(c);
      e = 64 >> s;
      `CHK("sel_rate", 1'b1, c >= 16'(e) && c <= 16'(e + 4))
      if (s == 0) `CHK("unit_step", 16'h0041, c)
    end
    wr8(16'hFF81, 8'h40);
    load(16'h0000);
    repeat (64) @(posedge clk);
    rdc(c);
    `CHK("sel_none", 16'h0000, c)
  endtask
  // clock enable low freezes count and tick.
  task automatic t_ce();
    logic [15:0] c;
    wr8(16'hFF81, 8'h00);
    load(16'h0000);
    ce <= 1'b0;
    repeat (20) @(posedge clk);
    ce <= 1'b1;
    rdc(c);
    `CHK("ce_freeze", 16'h0001, c)
  endtask
  task automatic t_ovf();
    logic [15:0] c;
    logic [7:0]  v;
    wr8(16'hFF81, 8'h00);
    load(16'hFFF0);
    repeat (40) @(posedge clk);
    `CHK("irq_gated", 1'b0, irq)
    rdc(c);
    `CHK("wrapped", 1'b1, c >= 16'h0018 && c <= 16'h0040)
    wr8(16'hFF80, 8'h00);
    wr8(16'hFF83, 8'h00);
    rd8(16'hFF83, v);
    `CHK("flag_set", 8'h80, v)
    wr8(16'hFF82, 8'h80);
    repeat (2) @(posedge clk);
    `CHK("irq_on", 1'b1, irq)
    wr8(16'hFF83, 8'h00);
    repeat (2) @(posedge clk);
    `CHK("irq_off", 1'b0, irq)
    rd8(16'hFF83, v);
    `CHK("flag_clear", 8'h00, v)
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // The whole run takes about six hundred cycles, so this limit leaves ample margin.
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_run();
    t_sel();
    t_ce();
    t_ovf();
    give_verdict();
  end
endmodule
`default_nettype wire
